// ---- nvc_pkg.sv ----
// Constants, field layout and types of the nonvolatile configuration
// write controller. Assumes a 50 MHz system clock.
package nvc_pkg;

  // ----------------------------------------------------------------
  // Bus protocol
  // ----------------------------------------------------------------
  localparam logic [3:0]  NVC_ADDR_HI     = 4'h9;    // Fixed upper address nibble
  localparam logic [7:0]  NVC_PTR_NV_CFG  = 8'h11;   // Pointer of this register
  localparam logic [3:0]  NVC_BITS_BYTE   = 4'h8;
  localparam logic [1:0]  NVC_DATA_BYTES  = 2'h2;

  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam logic [15:0] NVC_NV_FACTORY  = 16'h0000; // Shipped contents
  localparam logic [15:0] NVC_NV_WR_MASK  = 16'h7F06; // Bits software may set
  localparam int          NVC_BIT_LOCKDN  = 2;
  localparam int          NVC_BIT_LOCK    = 1;
  // Positions inside the copied upper byte
  localparam int          NVC_CFG_RES_LSB = 5;
  localparam int          NVC_CFG_FQ_LSB  = 3;
  localparam int          NVC_CFG_POL     = 2;
  localparam int          NVC_CFG_MODE    = 1;
  localparam int          NVC_CFG_SD      = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          NVC_CLK_MHZ      = 50;
  localparam int          NVC_PROG_TIME_US = 5000;  // Program cycle time, plain default
  localparam logic [7:0]  NVC_CONV_BASE_MS = 8'h19; // 25 ms at 9 bits
  localparam logic [3:0]  NVC_RES_BASE     = 4'h9;  // 9 bits at code 00

  typedef enum logic [1:0] {
    NVC_IDLE,
    NVC_ADDR,
    NVC_PTR,
    NVC_DATA
  } nvc_phase_e;

  // Fault queue code to consecutive faults needed
  function automatic logic [2:0] nvc_fault_count(input logic [1:0] code);
    case (code)
      2'h0:    nvc_fault_count = 3'h1;
      2'h1:    nvc_fault_count = 3'h2;
      2'h2:    nvc_fault_count = 3'h4;
      default: nvc_fault_count = 3'h6;
    endcase
  endfunction : nvc_fault_count

endpackage : nvc_pkg

// ---- nvc_pin_sync.sv ----
// Three-stage synchroniser for pin inputs.
// Assumes one system clock; output moves once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module nvc_pin_sync
  import nvc_pkg::*;
#(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } nvc_sync_s;

  nvc_sync_s st_ff;
  nvc_sync_s nxt_st;

  // Stage one feeds stage two only; agreement filters a late change
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
    if (i_rst) begin
      nxt_st = {4{RST_VAL}};
    end
  end

  always_ff @(posedge i_clk) begin
    st_ff <= nxt_st;
  end

  assign o_q = st_ff.q;

endmodule : nvc_pin_sync
`default_nettype wire

// ---- nvc_nv_config_ctrl.sv ----
// Write and lock control of the 16-bit nonvolatile power-up configuration.
// Assumes a 50 MHz clock, two-wire bus pins and an external pull-up on data.
//
// What this block does
// - Ack only address 1001 pins, write bit
// - Pointer byte 0x11 selects register, acked
// - Two data bytes; later bytes ignored
// - Fewer than two bytes: register unchanged
// - Valid write closed by Stop starts program
// - Busy bit high through program cycle
// - Repeated Start aborts, register unchanged
// - No program when busy or locked down; when locked, only to clear lock
// - Locked writes still acknowledge data bytes
// - Busy: ack address, pointer; nack data
// - Resolution code gives bits and conversion time
// - Fault code gives 1, 2, 4, 6 faults
// - Polarity bit sets alarm level after reset
// - Mode bit picks comparator or interrupt
// - Shutdown bit picks shutdown after reset
// - Lockdown refuses all configuration, limit changes
// - Lockdown bit returns to zero only on power-on
// - Lockdown outranks the reversible lock
// - Lock bit blocks configuration, limit writes
// - While locked only clearing lock allowed
// - Factory contents are all zero
// - Reset copies upper byte to volatile config
// - Fixed field placement, unused bits zero
`timescale 1ns/10ps
`default_nettype none
module nvc_nv_config_ctrl
  import nvc_pkg::*;
#(
  parameter int PROG_TIME_US = NVC_PROG_TIME_US
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_por,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic [2:0]  i_addr_pins,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic             o_nonvolatile_busy,
  output logic [15:0]      o_nv_config,
  output logic [7:0]       o_cfg_byte,
  output logic [3:0]       o_resolution_bits,
  output logic [7:0]       o_conv_time_ms,
  output logic [2:0]       o_fault_count,
  output logic             o_alarm_active_high,
  output logic             o_interrupt_mode,
  output logic             o_shutdown,
  output logic             o_regs_writable
);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PROG_CYCLES = PROG_TIME_US * NVC_CLK_MHZ;
  localparam int PCW         = $clog2(PROG_CYCLES + 1);
  localparam logic [PCW-1:0] PROG_LOAD = PCW'(PROG_CYCLES - 1);
  localparam logic [PCW-1:0] PROG_ONE  = PCW'(1);

  typedef struct packed {
    nvc_phase_e     phase;
    logic [3:0]     bit_cnt;
    logic           ack_ph;
    logic [7:0]     shreg;
    logic [1:0]     byte_n;
    logic [15:0]    data_buf;
    logic           scl_q;
    logic           sda_q;
    logic           sda_oe;
    logic           busy;
    logic [PCW-1:0] prog_cnt;
    logic [15:0]    nv;
    logic [15:0]    nv_pend;
    logic [7:0]     vcfg;
    logic [3:0]     res_bits;
    logic [7:0]     conv_ms;
    logic [2:0]     faults;
    logic           writable;
  } nvc_st_s;

  nvc_st_s     st_ff;
  nvc_st_s     nxt_st;
  logic [4:0]  pins_q;
  logic [2:0]  pin_addr;
  logic        pin_scl;
  logic        pin_sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  // ----------------------------------------------------------------
  // Pin synchronisation and bus conditions
  // ----------------------------------------------------------------
  nvc_pin_sync #(
    .W       (5),
    .RST_VAL (5'h1F)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_pin ({i_addr_pins, i_scl, i_sda}),
    .o_q   (pins_q)
  );

  assign pin_addr  = pins_q[4:2];
  assign pin_scl   = pins_q[1];
  assign pin_sda   = pins_q[0];
  assign scl_rise  = pin_scl & ~st_ff.scl_q;
  assign scl_fall  = ~pin_scl & st_ff.scl_q;
  // Data edges while the clock stays high mark Start and Stop
  assign start_det = st_ff.scl_q & pin_scl & st_ff.sda_q & ~pin_sda;
  assign stop_det  = st_ff.scl_q & pin_scl & ~st_ff.sda_q & pin_sda;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] new_nv;
    logic        do_prog;
    new_nv  = st_ff.nv;
    do_prog = 1'b0;
    nxt_st  = st_ff;
    nxt_st.scl_q = pin_scl;
    nxt_st.sda_q = pin_sda;

    // Program timer: value lands one cycle before busy drops
    if (st_ff.busy) begin
      nxt_st.prog_cnt = st_ff.prog_cnt - PROG_ONE;
      if (st_ff.prog_cnt == PROG_ONE) begin
        nxt_st.nv = st_ff.nv_pend;
      end
      if (st_ff.prog_cnt == '0) begin
        nxt_st.busy = 1'b0;
      end
    end

    if (start_det) begin
      // A Start in any phase drops partial or complete data
      nxt_st.phase   = NVC_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.ack_ph  = 1'b0;
      nxt_st.byte_n  = 2'h0;
      nxt_st.sda_oe  = 1'b0;
    end else if (stop_det) begin
      if (st_ff.phase == NVC_DATA && st_ff.byte_n == NVC_DATA_BYTES
          && !st_ff.busy) begin
        if (st_ff.nv[NVC_BIT_LOCKDN]) begin
          do_prog = 1'b0;
        end else if (st_ff.nv[NVC_BIT_LOCK]) begin
          // Only a write with the lock bit low may act, and only on it
          do_prog = ~st_ff.data_buf[NVC_BIT_LOCK];
          new_nv  = st_ff.nv;
          new_nv[NVC_BIT_LOCK] = 1'b0;
        end else begin
          do_prog = 1'b1;
          new_nv  = st_ff.data_buf & NVC_NV_WR_MASK;
        end
      end
      if (do_prog) begin
        nxt_st.busy     = 1'b1;
        nxt_st.prog_cnt = PROG_LOAD;
        nxt_st.nv_pend  = new_nv;
      end
      nxt_st.phase  = NVC_IDLE;
      nxt_st.ack_ph = 1'b0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.byte_n = 2'h0;
    end else if (st_ff.phase != NVC_IDLE) begin
      // Sample on the rising clock, skipping the acknowledge slot
      if (scl_rise && !st_ff.ack_ph) begin
        nxt_st.shreg   = {st_ff.shreg[6:0], pin_sda};
        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
      end
      if (scl_fall) begin
        if (st_ff.ack_ph) begin
          nxt_st.ack_ph = 1'b0;
          nxt_st.sda_oe = 1'b0;
        end else if (st_ff.bit_cnt == NVC_BITS_BYTE) begin
          nxt_st.bit_cnt = 4'h0;
          nxt_st.ack_ph  = 1'b1;
          case (st_ff.phase)
            NVC_ADDR: begin
              if (st_ff.shreg == {NVC_ADDR_HI, pin_addr, 1'b0}) begin
                nxt_st.sda_oe = 1'b1;
                nxt_st.phase  = NVC_PTR;
              end else begin
                nxt_st.phase  = NVC_IDLE;
              end
            end
            NVC_PTR: begin
              if (st_ff.shreg == NVC_PTR_NV_CFG) begin
                nxt_st.sda_oe = 1'b1;
                nxt_st.phase  = NVC_DATA;
              end else begin
                nxt_st.phase  = NVC_IDLE;
              end
            end
            NVC_DATA: begin
              // Locked writes are acked; busy writes are not
              nxt_st.sda_oe = ~st_ff.busy;
              if (!st_ff.busy && st_ff.byte_n != NVC_DATA_BYTES) begin
                nxt_st.byte_n = st_ff.byte_n + 2'h1;
                if (st_ff.byte_n == 2'h0) begin
                  nxt_st.data_buf[15:8] = st_ff.shreg;
                end else begin
                  nxt_st.data_buf[7:0]  = st_ff.shreg;
                end
              end
            end
            default: begin
              nxt_st.phase = NVC_IDLE;
            end
          endcase
        end
      end
    end

    // Reset copies the stored upper byte; power-on models a blank part
    if (i_rst || i_por) begin
      nxt_st.phase    = NVC_IDLE;
      nxt_st.bit_cnt  = 4'h0;
      nxt_st.ack_ph   = 1'b0;
      nxt_st.shreg    = 8'h00;
      nxt_st.byte_n   = 2'h0;
      nxt_st.data_buf = 16'h0000;
      nxt_st.scl_q    = 1'b1;
      nxt_st.sda_q    = 1'b1;
      nxt_st.sda_oe   = 1'b0;
      nxt_st.busy     = 1'b0;
      nxt_st.prog_cnt = '0;
      if (i_por) begin
        nxt_st.nv = NVC_NV_FACTORY;
      end else if (st_ff.busy) begin
        nxt_st.nv = st_ff.nv_pend;
      end
      nxt_st.nv_pend  = nxt_st.nv;
      nxt_st.vcfg     = nxt_st.nv[15:8];
      nxt_st.res_bits = NVC_RES_BASE
                        + {2'h0, nxt_st.nv[14:13]};
      nxt_st.conv_ms  = NVC_CONV_BASE_MS << nxt_st.nv[14:13];
      nxt_st.faults   = nvc_fault_count(nxt_st.nv[12:11]);
    end

    nxt_st.writable = ~(nxt_st.nv[NVC_BIT_LOCKDN]
                        | nxt_st.nv[NVC_BIT_LOCK]);
  end

  always_ff @(posedge i_clk) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain data: only ever pulls low
  assign o_sda_out           = 1'b0;
  assign o_sda_oe            = st_ff.sda_oe;
  assign o_nonvolatile_busy  = st_ff.busy;
  assign o_nv_config         = st_ff.nv;
  assign o_cfg_byte          = st_ff.vcfg;
  assign o_resolution_bits   = st_ff.res_bits;
  assign o_conv_time_ms      = st_ff.conv_ms;
  assign o_fault_count       = st_ff.faults;
  assign o_alarm_active_high = st_ff.vcfg[NVC_CFG_POL];
  assign o_interrupt_mode    = st_ff.vcfg[NVC_CFG_MODE];
  assign o_shutdown          = st_ff.vcfg[NVC_CFG_SD];
  assign o_regs_writable     = st_ff.writable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || i_por);

  chk_busy_holds: assert property (
    st_ff.busy && st_ff.prog_cnt != '0 |=> st_ff.busy)
    else $error("busy dropped before program cycle end");

  chk_nv_only_prog: assert property (
    $changed(st_ff.nv) |-> $past(st_ff.busy) && st_ff.busy)
    else $error("stored value changed outside a program cycle");

  chk_busy_cause: assert property (
    $rose(st_ff.busy) |-> $past(stop_det)
      && $past(st_ff.phase) == NVC_DATA && $past(st_ff.byte_n) == 2'h2)
    else $error("program started without a complete write and Stop");

  chk_lockdown_keeps: assert property (
    st_ff.nv[NVC_BIT_LOCKDN] |=> st_ff.nv[NVC_BIT_LOCKDN])
    else $error("lockdown bit returned to zero");

  chk_lock_clear_only: assert property (
    $changed(st_ff.nv) && $past(st_ff.nv[NVC_BIT_LOCK])
      |-> st_ff.nv == ($past(st_ff.nv) & ~16'h0002))
    else $error("locked write changed more than the lock bit");

  // Judged at the decision point: the pointer ack already sits in the data phase
  chk_busy_nack: assert property (
    scl_fall && !st_ff.ack_ph && st_ff.bit_cnt == NVC_BITS_BYTE
      && st_ff.phase == NVC_DATA && st_ff.busy |=> !st_ff.sda_oe)
    else $error("data byte acknowledged while busy");

  chk_fixed_bits: assert property (
    st_ff.nv[15] == 1'b0 && st_ff.nv[7:3] == 5'h00 && st_ff.nv[0] == 1'b0)
    else $error("unused stored bit is not zero");

  chk_writable_map: assert property (
    st_ff.nv[NVC_BIT_LOCKDN] |-> !o_regs_writable)
    else $error("locked down registers reported writable");

  // The master cannot end a frame while we hold data low, so only a falling clock frees it
  chk_ack_length: assert property (
    st_ff.sda_oe && !scl_fall |=> st_ff.sda_oe)
    else $error("acknowledge released early");

  chk_ack_addr: assert property (
    $rose(st_ff.sda_oe) && st_ff.phase == NVC_PTR
      |-> $past(st_ff.shreg) == {NVC_ADDR_HI, pin_addr, 1'b0})
    else $error("foreign address acknowledged");

  cov_program: cover property ($rose(st_ff.busy));
  cov_nack:    cover property (st_ff.ack_ph && st_ff.busy && st_ff.phase == NVC_DATA
                               && !st_ff.sda_oe);
  cov_unlock:  cover property ($fell(st_ff.nv[NVC_BIT_LOCK]));
  cov_abort:   cover property (start_det && st_ff.byte_n == 2'h2);

endmodule : nvc_nv_config_ctrl
`default_nettype wire

// ---- nvc_bus_master.sv ----
// Two-wire bus master model that drives write frames into the controller.
// Assumes a pull-up on data; the slave pulls data low through i_slave_oe.
`timescale 1ns/10ps
`default_nettype none
module nvc_bus_master (
  input  wire logic i_clk,
  input  wire logic i_slave_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic pull_low;
  // Wired-AND with pull-up, so a released line reads high
  assign o_sda = ~(pull_low | i_slave_oe);
  // Bus idles with both lines high; the clock stands still between frames
  initial begin
    o_scl    = 1'b1;
    pull_low = 1'b0;
  end
  // Ten clocks per phase keeps both clock halves above the minimum
  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask : gap
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    pull_low = 1'b0;
    gap(10);
    o_scl = 1'b1;
    gap(10);
    pull_low = 1'b1;
    gap(10);
    o_scl = 1'b0;
    gap(3);
  endtask : start
  // Eight bits MSB first, then a released ninth bit; data moves only with clock low
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      pull_low = (i > 0) ? ~b[i-1] : 1'b0;
      gap(10);
      o_scl = 1'b1;
      gap(10);
      ack = ~o_sda;
      o_scl = 1'b0;
      gap(3);
    end
  endtask : xfer
  // Stop: data rises while the clock is high
  task automatic stop();
    pull_low = 1'b1;
    gap(10);
    o_scl = 1'b1;
    gap(10);
    pull_low = 1'b0;
    gap(10);
  endtask : stop
endmodule : nvc_bus_master
`default_nettype wire

// ---- nvc_nv_config_ctrl_tb.sv ----
// Self-checking bench for the nonvolatile configuration write controller.
// Assumes the bus master model is compiled first; program time shortened.
`timescale 1ns/10ps
`default_nettype none
module nvc_nv_config_ctrl_tb;
  import nvc_pkg::*;
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] nv;
    logic [3:0]  res;
    logic [7:0]  conv;
    logic [2:0]  faults;
  } nvc_row_s;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_por = 1'b1;
  logic        scl, sda, oe, busy, pol, mode, sd, wr_ok;
  logic [15:0] nv;
  logic [7:0]  cfg, conv;
  logic [3:0]  res;
  logic [2:0]  fc;
  logic [4:0]  acks;
  int          miscompares = 0;
  int          comparisons = 0;
  int          tno = 0;
  nvc_row_s    rows [4] = '{'{16'hFFF9, 16'h7F00, 4'hC, 8'hC8, 3'h6},
                            '{16'h2A00, 16'h2A00, 4'hA, 8'h32, 3'h2},
                            '{16'h5500, 16'h5500, 4'hB, 8'h64, 3'h4},
                            '{16'h0081, 16'h0000, 4'h9, 8'h19, 3'h1}};
  // --------------------------------------------------------------
  // Clock, partner and design
  // --------------------------------------------------------------
  always #10 i_clk = ~i_clk;
  nvc_bus_master nvc_bus_master_inst (.i_clk(i_clk), .i_slave_oe(oe), .o_scl(scl), .o_sda(sda));
  // 30 us gives a 1500-cycle program, long enough to start a frame inside it
  nvc_nv_config_ctrl #(.PROG_TIME_US(30)) nvc_nv_config_ctrl_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_por(i_por), .i_scl(scl), .i_sda(sda), .i_addr_pins(3'h5),
    .o_sda_out(), .o_sda_oe(oe), .o_nonvolatile_busy(busy), .o_nv_config(nv),
    .o_cfg_byte(cfg), .o_resolution_bits(res), .o_conv_time_ms(conv), .o_fault_count(fc),
    .o_alarm_active_high(pol), .o_interrupt_mode(mode), .o_shutdown(sd),
    .o_regs_writable(wr_ok));
  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Reset pulse; the stored value must survive a plain device reset
  task automatic pulse(input logic por);
    i_rst = 1'b1;
    i_por = por;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    i_por = 1'b0;
    repeat (8) @(negedge i_clk);
  endtask : pulse
  // Volatile copy and decoded defaults after a reset
  task automatic cfg_chk(input nvc_row_s r);
    chk(cfg, r.nv[15:8]);
    chk(res, r.res);
    chk(conv, r.conv);
    chk(fc, r.faults);
    chk(pol, r.nv[10]);
    chk(mode, r.nv[9]);
    chk(sd, r.nv[8]);
  endtask : cfg_chk
  // One frame of n data bytes; wt waits out the program cycle under a bound
  task automatic run(input logic [7:0] a, input logic [7:0] p, input logic [15:0] d,
                     input int n, input logic rs, input logic [4:0] exp_ack,
                     input logic exp_busy, input logic [15:0] exp_nv, input logic wt);
    logic [7:0] b [5];
    int         k;
    b = '{a, p, d[15:8], d[7:0], 8'hC3};
    acks = '0;
    k = 0;
    nvc_bus_master_inst.start();
    for (int i = 0; i < n + 2; i++)
      nvc_bus_master_inst.xfer(b[i], acks[i]);
    if (rs)
      nvc_bus_master_inst.start();
    nvc_bus_master_inst.stop();
    chk(acks, exp_ack);
    chk(busy, exp_busy);
    while (wt && busy !== 1'b0 && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    if (wt)
      chk(busy, 1'b0);
    chk(nv, exp_nv);
    $display("frame %0d done at %0t", tno, $time);
    tno++;
  endtask : run
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    pulse(1'b1);
    cfg_chk(rows[3]);
    chk(nv, 16'h0000);
    chk(wr_ok, 1'b1);
    $display("reset test done");
    foreach (rows[i]) begin
      run(8'h9A, 8'h11, rows[i].data, 2, 1'b0, 5'h0F, 1'b1, rows[i].nv, 1'b1);
      pulse(1'b0);
      cfg_chk(rows[i]);
      chk(nv, rows[i].nv);
    end
    run(8'h98, 8'h11, 16'h2000, 2, 1'b0, 5'h00, 1'b0, 16'h0000, 1'b1);
    run(8'h9B, 8'h11, 16'h2000, 2, 1'b0, 5'h00, 1'b0, 16'h0000, 1'b1);
    run(8'h9A, 8'h01, 16'h2000, 2, 1'b0, 5'h01, 1'b0, 16'h0000, 1'b1);
    run(8'h9A, 8'h11, 16'h2000, 1, 1'b0, 5'h07, 1'b0, 16'h0000, 1'b1);
    run(8'h9A, 8'h11, 16'h2000, 2, 1'b1, 5'h0F, 1'b0, 16'h0000, 1'b1);
    run(8'h9A, 8'h11, 16'h4200, 3, 1'b0, 5'h1F, 1'b1, 16'h4200, 1'b1);
    // Second frame lands inside the first program cycle
    run(8'h9A, 8'h11, 16'h0600, 2, 1'b0, 5'h0F, 1'b1, 16'h4200, 1'b0);
    run(8'h9A, 8'h11, 16'h1800, 2, 1'b0, 5'h03, 1'b1, 16'h0600, 1'b1);
    run(8'h9A, 8'h11, 16'h0002, 2, 1'b0, 5'h0F, 1'b1, 16'h0002, 1'b1);
    chk(wr_ok, 1'b0);
    run(8'h9A, 8'h11, 16'h7F02, 2, 1'b0, 5'h0F, 1'b0, 16'h0002, 1'b1);
    run(8'h9A, 8'h11, 16'h7F00, 2, 1'b0, 5'h0F, 1'b1, 16'h0000, 1'b1);
    chk(wr_ok, 1'b1);
    run(8'h9A, 8'h11, 16'h0006, 2, 1'b0, 5'h0F, 1'b1, 16'h0006, 1'b1);
    run(8'h9A, 8'h11, 16'h0000, 2, 1'b0, 5'h0F, 1'b0, 16'h0006, 1'b1);
    pulse(1'b0);
    chk(nv, 16'h0006);
    chk(wr_ok, 1'b0);
    $display("lock tests done");
    tally_and_finish();
  end
  // Watchdog sized well above the roughly 28000 cycles the frames need
  initial begin
    repeat (90000) @(posedge i_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : nvc_nv_config_ctrl_tb
`default_nettype wire
